// file: bench/pes_link_peer.sv
// Next device on the link: frame decoder and frame sender
`timescale 1ns/1ns
module pes_link_peer (
	input  wire logic clkFromDut,
	input  wire logic dataFromDut,
	output logic      clkToDut,
	output logic      dataToDut
);
	int         bitNum = 0;
	int         pings = 0;
	int         bytes = 0;
	logic [7:0] shiftR;
	logic [7:0] lastByte;
	initial begin
		clkToDut = 1'b0;
		dataToDut = 1'b0;
	end
	// Bit count ends a frame; the clock stands still between frames
	always @(posedge clkFromDut) begin
		if (bitNum == 1 && dataFromDut === 1'b0) begin
			pings++;
			bitNum = 0;
		end else if (bitNum == 9) begin
			lastByte = {shiftR[6:0], dataFromDut};
			bytes++;
			bitNum = 0;
		end else begin
			shiftR = {shiftR[6:0], dataFromDut};
			bitNum++;
		end
	end
	task automatic sendFrame(input logic isData, input logic [7:0] b);
		logic [9:0] f;
		int         n;
		f = {1'b1, isData, b};
		n = isData ? 10 : 2;
		// Odd offset keeps the link clock off the system clock phase
		#37;
		for (int i = 0; i < n; i++) begin
			dataToDut = f[9 - i];
			#400 clkToDut = 1'b1;
			#400 clkToDut = 1'b0;
		end
		// Released line must not look like a held bit
		dataToDut = ~dataToDut;
	endtask
endmodule

// file: bench/pes_ping_sync_test.sv
// Self-checking bench for the ping event sync block
`timescale 1ns/1ns
module pes_ping_sync_test;
	localparam logic [31:0] NIL = 32'h0000_0000;
	logic        clock, reset, psel, penable, pwrite, pready, pslverr;
	logic        linkClkOut, linkDataOut, linkClkIn, linkDataIn;
	logic        txValid, txReady, rxValid, pwmCmpOut, pwmZero, syncIn;
	logic [7:0]  paddr, txData, rxData;
	logic [31:0] pwdata, prdata;
	int          miscompares = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          tRise, tFall, tZero, d1, d2;
	int          syncs = 0;
	int          clkRises = 0;
	pes_ping_sync pes_ping_sync_inst (
		.clock(clock), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .linkClkOut(linkClkOut),
		.linkDataOut(linkDataOut), .linkClkIn(linkClkIn),
		.linkDataIn(linkDataIn), .txValid(txValid), .txData(txData),
		.txReady(txReady), .rxValid(rxValid), .rxData(rxData),
		.pwmCmpOut(pwmCmpOut), .pwmZero(pwmZero), .syncIn(syncIn)
	);
	pes_link_peer pes_link_peer_inst (
		.clkFromDut(linkClkOut), .dataFromDut(linkDataOut),
		.clkToDut(linkClkIn), .dataToDut(linkDataIn)
	);
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// Counting on the falling edge keeps event stamps race free
	always @(negedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			final_report();
		end
	end
	always @(posedge pwmCmpOut) tRise = cyc;
	always @(negedge pwmCmpOut) tFall = cyc;
	always @(posedge pwmZero) tZero = cyc;
	always @(posedge syncIn) syncs++;
	always @(posedge linkClkOut) clkRises++;
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, input logic [31:0] exp, input logic errExp);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		check("pslverr", 32'(errExp), 32'(pslverr));
		if (!wr) check($sformatf("reg %h", a), exp, prdata);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, NIL, 1'b0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, NIL, e, 1'b0);
	endtask
	task automatic t_regs;
		rd(pes_pkg::ADDR_CTRL, 32'(pes_pkg::CTRL_RST));
		rd(pes_pkg::ADDR_PERIOD, 32'(pes_pkg::PERIOD_RST));
		rd(pes_pkg::ADDR_CMP, 32'(pes_pkg::CMP_RST));
		rd(pes_pkg::ADDR_PRESC, 32'(pes_pkg::PRESC_RST));
		rd(pes_pkg::ADDR_MATCH, 32'(pes_pkg::MATCH_RST));
		apb(1'b1, 8'h18, 32'hFFFF_FFFF, NIL, 1'b1);
		apb(1'b0, 8'h18, NIL, NIL, 1'b1);
		wr(pes_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
		rd(pes_pkg::ADDR_STATUS, NIL);
	endtask
	task automatic t_down;
		int p0;
		p0 = pes_link_peer_inst.pings;
		wr(pes_pkg::ADDR_PERIOD, 32'hFFFF_0013);
		rd(pes_pkg::ADDR_PERIOD, 32'h0000_0013);
		wr(pes_pkg::ADDR_CTRL, 32'h0000_0002);
		repeat (100) @(posedge clock);
		check("lead pings", p0, pes_link_peer_inst.pings);
		wr(pes_pkg::ADDR_CTRL, NIL);
		pes_link_peer_inst.sendFrame(1'b0, 8'h00);
		repeat (40) @(posedge clock);
		check("syncs", NIL, syncs);
		check("fwd pings", p0, pes_link_peer_inst.pings);
	endtask
	task automatic t_lead(input logic edgeSel, input logic [3:0] presc,
		input logic [15:0] cmp);
		int t1;
		int c1;
		int n;
		wr(pes_pkg::ADDR_CMP, 32'(cmp));
		wr(pes_pkg::ADDR_PRESC, 32'(presc));
		wr(pes_pkg::ADDR_CTRL, {29'h0000_0000, edgeSel, 2'h3});
		repeat (2) @(posedge linkDataOut);
		t1 = cyc;
		c1 = clkRises;
		@(posedge linkDataOut);
		// A zero prescale launches on every compare event
		n = (presc == 4'h0) ? 1 : int'(presc);
		check("interval", 20 * n, cyc - t1);
		check("ping clocks", 2, clkRises - c1);
		t1 = cyc - (edgeSel ? tFall : tRise);
		check("edge lag", 1, t1 inside {[1:4]});
		if (!edgeSel) check("cmp pos", cmp, tRise - tZero);
	endtask
	task automatic t_data;
		int b0;
		int c1;
		wr(pes_pkg::ADDR_CTRL, 32'h0000_0001);
		repeat (40) @(posedge clock);
		b0 = pes_link_peer_inst.bytes;
		c1 = clkRises;
		txData <= 8'hA5;
		txValid <= 1'b1;
		do @(posedge clock); while (txReady !== 1'b1);
		txValid <= 1'b0;
		while (pes_link_peer_inst.bytes == b0) @(posedge clock);
		check("tx byte", 32'h0000_00A5, pes_link_peer_inst.lastByte);
		check("tx clocks", 10, clkRises - c1);
		fork
			pes_link_peer_inst.sendFrame(1'b1, 8'h3C);
		join_none
		do @(posedge clock); while (rxValid !== 1'b1);
		check("rx byte", 32'h0000_003C, rxData);
		repeat (20) @(posedge clock);
	endtask
	task automatic t_node(input logic [15:0] m, output int d);
		int tf;
		int s0;
		int p0;
		wr(pes_pkg::ADDR_MATCH, 32'(m));
		s0 = syncs;
		p0 = pes_link_peer_inst.pings;
		fork
			pes_link_peer_inst.sendFrame(1'b0, 8'h00);
		join_none
		@(posedge linkDataOut);
		tf = cyc;
		@(posedge syncIn);
		d = cyc - tf;
		@(posedge clock);
		@(negedge clock);
		check("sync width", NIL, syncIn);
		repeat (3) @(posedge clock);
		check("pwm restart", 1, (tZero - tf - d) inside {[0:3]});
		repeat (3 * m + 40) @(posedge clock);
		check("sync count", s0 + 1, syncs);
		check("fwd pings", p0 + 1, pes_link_peer_inst.pings);
	endtask
	task automatic final_report;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = NIL;
		txValid = 1'b0;
		txData = 8'h00;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		t_regs();
		t_down();
		t_lead(1'b0, 4'h1, 16'h000A);
		t_lead(1'b0, 4'h0, 16'h000A);
		t_lead(1'b0, 4'hF, 16'h0005);
		t_lead(1'b1, 4'h3, 16'h000A);
		t_data();
		t_node(16'h0028, d1);
		t_node(16'h000A, d2);
		check("match diff", 30, d1 - d2);
		check("fwd first", 1, d2 inside {[1:12]});
		final_report();
	end
endmodule

// file: hw/pes_ping_sync.sv
// Ping event sync: lead launcher, node forwarder, delay counter, link
//
// Contract
// - No pings sent or taken until software marks the handshake done.
// - Lead sends a sync ping periodically, like a timer.
// - Lead ping comes from a local PWM compare event, compare programmable.
// - Lead launches on rising or falling compare edge, by setting.
// - Sync request is a ping frame, the shortest frame type.
// - Pings and data share one clock line and one data line.
// - Node forwards a received ping at once, without waiting; the code holds it in pingPend_r until the transmitter is idle.
// - Node delay counter runs from zero up to programmable match, then stops until the next ping.
// - Ping starts delay counter; on match a sync-in pulse goes out.
// - Lead launch prescaled: ping every Nth compare event, N up to 15.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module pes_ping_sync (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             linkClkOut,
	output logic             linkDataOut,
	input  wire logic        linkClkIn,
	input  wire logic        linkDataIn,
	input  wire logic        txValid,
	input  wire logic [7:0]  txData,
	output logic             txReady,
	output logic             rxValid,
	output logic      [7:0]  rxData,
	output logic             pwmCmpOut,
	output logic             pwmZero,
	output logic             syncIn
);
	logic [2:0]  ctrl_r;
	logic [15:0] period_r, cmp_r, match_r, pwmCnt_r, dlyCnt_r;
	logic [3:0]  presc_r, preCnt_r, presLimit, txBitsLeft_r;
	logic [7:0]  txPingCnt_r, rxPingCnt_r, rxShift_r;
	logic [2:0]  txPhase_r, rxCnt_r;
	logic [9:0]  txShift_r;
	logic        linkUp, leadMode, edgeFall, cmpPrev_r, cmpEvent, leadLaunch;
	logic        pingPend_r, txStart, fwdPing, rxPing, dlyRun_r, acc, mapped;
	logic        lcS1, lcS2, lcS3, ldS1, ldS2, lcRise;
	logic [31:0] rdMux;
	pes_pkg::pes_tx_t txState_r;
	pes_pkg::pes_rx_t rxState_r;

	assign linkUp   = ctrl_r[pes_pkg::CTRL_LINKUP_BIT];
	assign leadMode = ctrl_r[pes_pkg::CTRL_LEAD_BIT];
	assign edgeFall = ctrl_r[pes_pkg::CTRL_EDGE_BIT];

	// APB slave, zero wait states
	assign pready = 1'b1;
	assign acc    = psel & penable;
	always_comb begin
		mapped = 1'b1;
		rdMux  = 32'h0000_0000;
		case (paddr)
		pes_pkg::ADDR_CTRL:   rdMux = {29'h0, ctrl_r};
		pes_pkg::ADDR_PERIOD: rdMux = {16'h0000, period_r};
		pes_pkg::ADDR_CMP:    rdMux = {16'h0000, cmp_r};
		pes_pkg::ADDR_PRESC:  rdMux = {28'h000_0000, presc_r};
		pes_pkg::ADDR_MATCH:  rdMux = {16'h0000, match_r};
		pes_pkg::ADDR_STATUS: rdMux = {15'h0000, txState_r == pes_pkg::TX_SEND,
			rxPingCnt_r, txPingCnt_r};
		default:              mapped = 1'b0;
		endcase
	end
	assign pslverr = acc & ~mapped;

	always_ff @(posedge clock) begin
		if (reset)
			prdata <= 32'h0000_0000;
		else if (psel & ~penable)
			prdata <= rdMux;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ctrl_r   <= pes_pkg::CTRL_RST;
			period_r <= pes_pkg::PERIOD_RST;
			cmp_r    <= pes_pkg::CMP_RST;
			presc_r  <= pes_pkg::PRESC_RST;
			match_r  <= pes_pkg::MATCH_RST;
		end else if (acc & pwrite) begin
			case (paddr)
			pes_pkg::ADDR_CTRL:   ctrl_r   <= pwdata[2:0];
			pes_pkg::ADDR_PERIOD: period_r <= pwdata[15:0];
			pes_pkg::ADDR_CMP:    cmp_r    <= pwdata[15:0];
			pes_pkg::ADDR_PRESC:  presc_r  <= pwdata[3:0];
			pes_pkg::ADDR_MATCH:  match_r  <= pwdata[15:0];
			default: ;
			endcase
		end
	end

	// PWM timebase; a node's sync-in pulls it back to zero
	always_ff @(posedge clock) begin
		if (reset) begin
			pwmCnt_r  <= 16'h0000;
			pwmCmpOut <= 1'b0;
			cmpPrev_r <= 1'b0;
			pwmZero   <= 1'b0;
		end else begin
			if ((syncIn & ~leadMode) || pwmCnt_r >= period_r)
				pwmCnt_r <= 16'h0000;
			else
				pwmCnt_r <= pwmCnt_r + 16'h0001;
			pwmCmpOut <= pwmCnt_r >= cmp_r;
			cmpPrev_r <= pwmCmpOut;
			pwmZero   <= pwmCnt_r == 16'h0000;
		end
	end

	assign cmpEvent = edgeFall ? (cmpPrev_r & ~pwmCmpOut)
		: (~cmpPrev_r & pwmCmpOut);

	// Zero prescale is taken as one so launching never stops silently
	assign presLimit  = (presc_r == 4'h0) ? 4'h1 : presc_r;
	assign leadLaunch = cmpEvent & leadMode & linkUp
		& (preCnt_r == presLimit - 4'h1);

	always_ff @(posedge clock) begin
		if (reset || !(leadMode && linkUp))
			preCnt_r <= 4'h0;
		else if (cmpEvent)
			preCnt_r <= leadLaunch ? 4'h0 : preCnt_r + 4'h1;
	end

	// Ping request: launch or forward sets, frame start clears, set wins
	assign fwdPing = rxPing & ~leadMode;
	always_ff @(posedge clock) begin
		if (reset)
			pingPend_r <= 1'b0;
		else if (leadLaunch | fwdPing)
			pingPend_r <= 1'b1;
		else if (txStart)
			pingPend_r <= 1'b0;
	end

	// Transmitter; pings take priority over data on the shared lines
	assign txReady = txState_r == pes_pkg::TX_IDLE && linkUp && !pingPend_r;
	assign txStart = txState_r == pes_pkg::TX_IDLE && linkUp
		&& (pingPend_r || txValid);
	always_ff @(posedge clock) begin
		if (reset) begin
			txState_r    <= pes_pkg::TX_IDLE;
			txShift_r    <= 10'h000;
			txBitsLeft_r <= 4'h0;
			txPhase_r    <= 3'h0;
			txPingCnt_r  <= 8'h00;
		end else begin
			case (txState_r)
			pes_pkg::TX_IDLE: begin
				txPhase_r <= 3'h0;
				if (txStart) begin
					txState_r <= pes_pkg::TX_SEND;
					if (pingPend_r) begin
						txShift_r    <= {2'b10, 8'h00};
						txBitsLeft_r <= pes_pkg::PING_BITS;
						txPingCnt_r  <= txPingCnt_r + 8'h01;
					end else begin
						txShift_r    <= {2'b11, txData};
						txBitsLeft_r <= pes_pkg::DATA_BITS;
					end
				end
			end
			pes_pkg::TX_SEND: begin
				if (txPhase_r == pes_pkg::BIT_LAST) begin
					txPhase_r    <= 3'h0;
					txShift_r    <= {txShift_r[8:0], 1'b0};
					txBitsLeft_r <= txBitsLeft_r - 4'h1;
					if (txBitsLeft_r == 4'h1)
						txState_r <= pes_pkg::TX_IDLE;
				end else begin
					txPhase_r <= txPhase_r + 3'h1;
				end
			end
			default: txState_r <= pes_pkg::TX_IDLE;
			endcase
		end
	end

	// Clock stays low between frames; data set while clock is low
	always_ff @(posedge clock) begin
		if (reset) begin
			linkClkOut  <= 1'b0;
			linkDataOut <= 1'b0;
		end else begin
			linkClkOut  <= txState_r == pes_pkg::TX_SEND
				&& txPhase_r >= pes_pkg::HALF_CYC;
			linkDataOut <= txState_r == pes_pkg::TX_SEND && txShift_r[9];
		end
	end

	// Receiver: link pins come from another clock, two flops first
	always_ff @(posedge clock) begin
		if (reset) begin
			{lcS1, lcS2, lcS3} <= 3'b000;
			{ldS1, ldS2}       <= 2'b00;
		end else begin
			lcS1 <= linkClkIn;
			lcS2 <= lcS1;
			lcS3 <= lcS2;
			ldS1 <= linkDataIn;
			ldS2 <= ldS1;
		end
	end
	assign lcRise = lcS2 & ~lcS3;

	always_ff @(posedge clock) begin
		if (reset) begin
			rxState_r   <= pes_pkg::RX_IDLE;
			rxPing      <= 1'b0;
			rxValid     <= 1'b0;
			rxShift_r   <= 8'h00;
			rxData      <= 8'h00;
			rxCnt_r     <= 3'h0;
			rxPingCnt_r <= 8'h00;
		end else begin
			rxPing  <= 1'b0;
			rxValid <= 1'b0;
			case (rxState_r)
			pes_pkg::RX_IDLE:
				if (lcRise && ldS2)
					rxState_r <= pes_pkg::RX_TYPE;
			pes_pkg::RX_TYPE:
				if (lcRise) begin
					rxCnt_r <= 3'h0;
					if (ldS2) begin
						rxState_r <= pes_pkg::RX_DATA;
					end else begin
						rxState_r   <= pes_pkg::RX_IDLE;
						rxPing      <= linkUp;
						rxPingCnt_r <= rxPingCnt_r + {7'h00, linkUp};
					end
				end
			pes_pkg::RX_DATA:
				if (lcRise) begin
					rxShift_r <= {rxShift_r[6:0], ldS2};
					rxCnt_r   <= rxCnt_r + 3'h1;
					if (rxCnt_r == pes_pkg::BYTE_LAST) begin
						rxState_r <= pes_pkg::RX_IDLE;
						rxData    <= {rxShift_r[6:0], ldS2};
						rxValid   <= 1'b1;
					end
				end
			default: rxState_r <= pes_pkg::RX_IDLE;
			endcase
		end
	end

	// Node delay counter; a new ping restarts it from zero
	always_ff @(posedge clock) begin
		if (reset) begin
			dlyRun_r <= 1'b0;
			dlyCnt_r <= 16'h0000;
			syncIn   <= 1'b0;
		end else begin
			syncIn <= 1'b0;
			if (rxPing && !leadMode) begin
				dlyRun_r <= 1'b1;
				dlyCnt_r <= 16'h0000;
			end else if (dlyRun_r) begin
				if (dlyCnt_r == match_r) begin
					syncIn   <= 1'b1;
					dlyRun_r <= 1'b0;
					dlyCnt_r <= 16'h0000;
				end else begin
					dlyCnt_r <= dlyCnt_r + 16'h0001;
				end
			end
		end
	end

	property p_noTxBeforeUp;
		@(posedge clock) disable iff (reset)
		txStart |-> linkUp;
	endproperty
	a_noTxBeforeUp: assert property (p_noTxBeforeUp)
		else $error("frame started before link up");

	property p_launchPends;
		@(posedge clock) disable iff (reset)
		leadLaunch |=> pingPend_r || $past(txStart) == 1'b0 && txState_r
			== pes_pkg::TX_SEND;
	endproperty
	a_launchPends: assert property (p_launchPends)
		else $error("lead launch lost");

	property p_launchFromCmp;
		@(posedge clock) disable iff (reset)
		leadLaunch |-> cmpEvent && leadMode;
	endproperty
	a_launchFromCmp: assert property (p_launchFromCmp)
		else $error("launch without compare event");

	property p_edgeSel;
		@(posedge clock) disable iff (reset)
		cmpEvent |-> (edgeFall ? $fell(pwmCmpOut) : $rose(pwmCmpOut));
	endproperty
	a_edgeSel: assert property (p_edgeSel)
		else $error("compare edge mismatch");

	property p_pingLen;
		@(posedge clock) disable iff (reset)
		txStart && pingPend_r |=> txState_r == pes_pkg::TX_SEND ##15
			txState_r == pes_pkg::TX_SEND ##1 txState_r == pes_pkg::TX_IDLE;
	endproperty
	a_pingLen: assert property (p_pingLen)
		else $error("ping frame length wrong");

	property p_quietLine;
		@(posedge clock) disable iff (reset)
		txState_r == pes_pkg::TX_IDLE ##1 txState_r == pes_pkg::TX_IDLE
			|-> !linkClkOut && !linkDataOut;
	endproperty
	a_quietLine: assert property (p_quietLine)
		else $error("link driven outside frame");

	property p_forward;
		@(posedge clock) disable iff (reset)
		rxPing && !leadMode |=> pingPend_r || txState_r == pes_pkg::TX_SEND;
	endproperty
	a_forward: assert property (p_forward)
		else $error("ping not forwarded");

	property p_syncAtMatch;
		@(posedge clock) disable iff (reset)
		syncIn |-> $past(dlyCnt_r) == $past(match_r) && dlyCnt_r == 16'h0000;
	endproperty
	a_syncAtMatch: assert property (p_syncAtMatch)
		else $error("sync-in not at match");

	property p_pingStarts;
		@(posedge clock) disable iff (reset)
		rxPing && !leadMode |=> dlyRun_r && dlyCnt_r == 16'h0000;
	endproperty
	a_pingStarts: assert property (p_pingStarts)
		else $error("delay counter not started");

	property p_prescale;
		@(posedge clock) disable iff (reset)
		leadLaunch |-> preCnt_r == presLimit - 4'h1 && presLimit <= 4'hF;
	endproperty
	a_prescale: assert property (p_prescale)
		else $error("prescale count wrong");

	property p_onePulse;
		@(posedge clock) disable iff (reset)
		syncIn |-> $past(dlyRun_r) && !dlyRun_r ##1 !syncIn;
	endproperty
	a_onePulse: assert property (p_onePulse)
		else $error("sync-in not single pulse");

	c_leadPing: cover property (@(posedge clock) disable iff (reset)
		leadLaunch ##[1:20] txState_r == pes_pkg::TX_SEND);
	c_nodeSync: cover property (@(posedge clock) disable iff (reset)
		rxPing ##[1:100] syncIn);
	c_dataByte: cover property (@(posedge clock) disable iff (reset)
		rxValid);
endmodule

// file: hw/pes_pkg.sv
// Constants for the ping event synchronisation block
package pes_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_PERIOD = 8'h04;
	localparam logic [7:0] ADDR_CMP    = 8'h08;
	localparam logic [7:0] ADDR_PRESC  = 8'h0C;
	localparam logic [7:0] ADDR_MATCH  = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;

	// Control fields
	localparam int CTRL_LINKUP_BIT = 0;
	localparam int CTRL_LEAD_BIT   = 1;
	localparam int CTRL_EDGE_BIT   = 2;
	localparam int CTRL_W          = 3;

	// Reset values
	localparam logic [2:0]  CTRL_RST   = 3'h0;
	localparam logic [15:0] PERIOD_RST = 16'h0063;
	localparam logic [15:0] CMP_RST    = 16'h0032;
	localparam logic [3:0]  PRESC_RST  = 4'h1;
	localparam logic [15:0] MATCH_RST  = 16'h0000;

	// Status fields
	localparam int STAT_TXCNT_LSB = 0;
	localparam int STAT_RXCNT_LSB = 8;
	localparam int STAT_BUSY_BIT  = 16;

	// Link timing
	localparam int CLK_PERIOD_NS  = 100;
	localparam int LINK_PERIOD_NS = 800;
	localparam int HALF_CYC_I     = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [2:0] HALF_CYC = 3'(HALF_CYC_I);
	localparam logic [2:0] BIT_LAST = 3'(2 * HALF_CYC_I - 1);

	// Frame shape: start bit, type bit, optional data byte
	localparam logic [3:0] PING_BITS = 4'h2;
	localparam logic [3:0] DATA_BITS = 4'hA;
	localparam logic [2:0] BYTE_LAST = 3'h7;

	typedef enum logic [0:0] {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} pes_tx_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_TYPE = 2'b01,
		RX_DATA = 2'b10
	} pes_rx_t;
endpackage
